// file: hw/cdb_pkg.sv
// constants and types shared by the compare / count-down / bcd datapath
package cdb_pkg;

  // ----------------------------------------------------------------
  // datapath widths and operand limits
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FILE_ADDR_W = 6;
  localparam logic [5:0] MAX_FILE_ADDR = 6'h3F;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [7:0] ONE_VAL = 8'h01;
  localparam logic [7:0] ZERO_VAL = 8'h00;

  // ----------------------------------------------------------------
  // decimal adjust constants
  // ----------------------------------------------------------------
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  localparam logic [8:0] BCD_FIX_LOW = 9'h006;
  localparam logic [8:0] BCD_FIX_HIGH = 9'h060;

  // ----------------------------------------------------------------
  // register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam int BUS_ADDR_W = 4;
  localparam logic [3:0] FLAGS_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] OPCNT_OFS = 4'h8;
  localparam int FLAG_Z_BIT = 0;
  localparam int FLAG_C_BIT = 1;
  localparam int FLAG_DC_BIT = 2;
  localparam int STAT_OP_LSB = 0;
  localparam int STAT_SKIP_BIT = 2;
  localparam int STAT_READY_BIT = 3;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
  localparam int OPCNT_W = 16;

  // ----------------------------------------------------------------
  // timing: cycles per instruction
  // ----------------------------------------------------------------
  localparam int PLAIN_CYCLES = 1;
  localparam int SKIP_CYCLES = 2;

  // ----------------------------------------------------------------
  // operation codes and state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    compare_op = 2'b00,
    count_down_op = 2'b01,
    count_down_skip_op = 2'b10,
    bcd_adjust_op = 2'b11
  } cdb_op_t;

  typedef enum logic [0:0] {
    exec_ready = 1'b0,
    exec_nop = 1'b1
  } cdb_exec_t;

  typedef enum logic [0:0] {
    bus_idle = 1'b0,
    bus_ack = 1'b1
  } cdb_bus_t;

endpackage : cdb_pkg

// file: hw/cdb_bcd_adjust.sv
// decimal adjust of the working register after a binary addition
`timescale 1ns/1ps
module cdb_bcd_adjust
  import cdb_pkg::*;
(
  input wire logic [7:0] bin_val,
  input wire logic carry_in,
  input wire logic digit_carry_in,
  output logic [7:0] bcd_val,
  output logic carry_out
);

  logic lo_fix;
  logic hi_fix;
  logic [8:0] sum;

  // ----------------------------------------------------------------
  // correction terms
  // ----------------------------------------------------------------
  // high fix looks at the whole byte so a low-digit correction that
  // ripples into a 9 in the high digit is still caught
  always_comb begin
    lo_fix = digit_carry_in || (bin_val[3:0] > BCD_DIGIT_MAX);
    hi_fix = carry_in || (bin_val > BCD_BYTE_MAX);
    sum = {1'b0, bin_val};
    if (lo_fix) begin
      sum = sum + BCD_FIX_LOW;
    end
    if (hi_fix) begin
      sum = sum + BCD_FIX_HIGH;
    end
    bcd_val = sum[7:0];
    carry_out = hi_fix || sum[8];
  end

endmodule : cdb_bcd_adjust

// file: hw/cdb_alu.sv
// compare, count-down, count-down-skip and bcd adjust datapath with flag and bus logic
`timescale 1ns/1ps
// Notes on behaviour
// - compare subtracts the working register from the addressed file register and sets zero and carry from it.
// - compare writes no result anywhere and completes in one instruction cycle.
// - count-down writes file value minus one to the working register (dest 0) or the file (dest 1), touches only zero, one cycle.
// - count-down-skip stores file value minus one to the destination picked exactly as for count-down.
// - a zero count-down-skip result drops the fetched instruction and runs a nop, two cycles; otherwise one.
// - bcd adjust turns the binary sum in the working register into packed decimal, writes it back, changes only carry.
module cdb_alu
  import cdb_pkg::*;
#(
  parameter int ADDR_W = FILE_ADDR_W
)(
  input wire logic sys_clk,
  input wire logic arst_n,
  // instruction side, from the decoder on the same clock
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic op_dest,
  input wire logic [ADDR_W-1:0] op_file_addr,
  input wire logic [7:0] file_data,
  input wire logic [7:0] acc_data,
  // flag updates from instructions outside this block
  input wire logic ext_flag_we,
  input wire logic ext_z,
  input wire logic ext_c,
  input wire logic ext_dc,
  output logic op_ready,
  output logic res_valid,
  output logic [7:0] res_data,
  output logic res_to_acc,
  output logic res_to_file,
  output logic [ADDR_W-1:0] res_file_addr,
  output logic skip_fetched,
  output logic flag_z,
  output logic flag_c,
  output logic flag_dc,
  // avalon-mm slave
  input wire logic [BUS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the file space is at most 64 entries; a wider port has no meaning
  if (ADDR_W < 1 || ADDR_W > FILE_ADDR_W) begin : g_bad_addr_w
    $error("cdb_alu: ADDR_W must be 1..6");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cdb_exec_t exec;
    logic ready;
    logic valid;
    logic [7:0] data;
    logic to_acc;
    logic to_file;
    logic [ADDR_W-1:0] addr;
    logic skip;
    logic z;
    logic c;
    logic dc;
    cdb_op_t last_op;
    logic [OPCNT_W-1:0] opcnt;
    cdb_bus_t bus;
    logic wait_req;
    logic [31:0] rdata;
  } cdb_state_t;

  cdb_state_t state_r;
  cdb_state_t state_nxt;

  logic take;
  cdb_op_t op;
  logic [7:0] dec_val;
  logic [8:0] cmp_diff;
  logic [7:0] bcd_val;
  logic bcd_carry;

  // ----------------------------------------------------------------
  // decimal adjust unit
  // ----------------------------------------------------------------
  cdb_bcd_adjust u_bcd (
    .bin_val(acc_data),
    .carry_in(state_r.c),
    .digit_carry_in(state_r.dc),
    .bcd_val(bcd_val),
    .carry_out(bcd_carry)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    take = op_valid && state_r.ready;
    op = cdb_op_t'(op_code);
    dec_val = file_data - ONE_VAL;
    cmp_diff = {1'b0, file_data} - {1'b0, acc_data};

    // result strobes last one cycle
    state_nxt.valid = 1'b0;
    state_nxt.skip = 1'b0;
    state_nxt.to_acc = 1'b0;
    state_nxt.to_file = 1'b0;

    // bus writes to the flags lose to instructions in the same cycle
    if (state_r.bus == bus_ack && avs_write && avs_address == FLAGS_OFS && avs_byteenable[0] && !take) begin
      state_nxt.z = avs_writedata[FLAG_Z_BIT];
      state_nxt.c = avs_writedata[FLAG_C_BIT];
      state_nxt.dc = avs_writedata[FLAG_DC_BIT];
    end
    if (ext_flag_we && !take) begin
      state_nxt.z = ext_z;
      state_nxt.c = ext_c;
      state_nxt.dc = ext_dc;
    end

    case (state_r.exec)
      exec_ready: begin
        if (take) begin
          state_nxt.valid = 1'b1;
          state_nxt.addr = op_file_addr;
          state_nxt.last_op = op;
          state_nxt.opcnt = state_r.opcnt + 1'b1;
          case (op)
            compare_op: begin
              // difference goes out on res_data with no write strobe; only flags move
              state_nxt.data = cmp_diff[7:0];
              state_nxt.z = (cmp_diff[7:0] == ZERO_VAL);
              state_nxt.c = !cmp_diff[8];
            end
            count_down_op: begin
              state_nxt.data = dec_val;
              state_nxt.to_acc = (op_dest == DEST_ACC);
              state_nxt.to_file = (op_dest == DEST_FILE);
              state_nxt.z = (dec_val == ZERO_VAL);
            end
            count_down_skip_op: begin
              state_nxt.data = dec_val;
              state_nxt.to_acc = (op_dest == DEST_ACC);
              state_nxt.to_file = (op_dest == DEST_FILE);
              state_nxt.z = (dec_val == ZERO_VAL);
              if (dec_val == ZERO_VAL) begin
                // fetched word is already in the pipe; a nop cycle replaces it
                state_nxt.skip = 1'b1;
                state_nxt.ready = 1'b0;
                state_nxt.exec = exec_nop;
              end
            end
            bcd_adjust_op: begin
              // relies on the addition just before it having left c and dc
              state_nxt.data = bcd_val;
              state_nxt.to_acc = 1'b1;
              state_nxt.c = bcd_carry;
            end
            default: begin
              state_nxt.valid = 1'b0;
            end
          endcase
        end
      end
      exec_nop: begin
        state_nxt.ready = 1'b1;
        state_nxt.exec = exec_ready;
      end
      default: begin
        state_nxt.exec = exec_ready;
        state_nxt.ready = 1'b1;
      end
    endcase

    // bus slave: one wait cycle, then the answer
    case (state_r.bus)
      bus_idle: begin
        if (avs_read || avs_write) begin
          state_nxt.bus = bus_ack;
          state_nxt.wait_req = 1'b0;
          state_nxt.rdata = UNMAPPED_VAL;
          if (avs_read) begin
            case (avs_address)
              FLAGS_OFS: begin
                state_nxt.rdata[FLAG_Z_BIT] = state_r.z;
                state_nxt.rdata[FLAG_C_BIT] = state_r.c;
                state_nxt.rdata[FLAG_DC_BIT] = state_r.dc;
              end
              STATUS_OFS: begin
                state_nxt.rdata[STAT_OP_LSB +: 2] = state_r.last_op;
                state_nxt.rdata[STAT_SKIP_BIT] = (state_r.exec == exec_nop);
                state_nxt.rdata[STAT_READY_BIT] = state_r.ready;
              end
              OPCNT_OFS: begin
                state_nxt.rdata[OPCNT_W-1:0] = state_r.opcnt;
              end
              default: begin
                state_nxt.rdata = UNMAPPED_VAL;
              end
            endcase
          end
        end
      end
      bus_ack: begin
        state_nxt.bus = bus_idle;
        state_nxt.wait_req = 1'b1;
      end
      default: begin
        state_nxt.bus = bus_idle;
        state_nxt.wait_req = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '{exec: exec_ready, ready: 1'b1, valid: 1'b0, data: 8'h00, to_acc: 1'b0,
                   to_file: 1'b0, addr: '0, skip: 1'b0, z: 1'b0, c: 1'b0, dc: 1'b0,
                   last_op: compare_op, opcnt: '0, bus: bus_idle, wait_req: 1'b1,
                   rdata: 32'h0000_0000};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign op_ready = state_r.ready;
  assign res_valid = state_r.valid;
  assign res_data = state_r.data;
  assign res_to_acc = state_r.to_acc;
  assign res_to_file = state_r.to_file;
  assign res_file_addr = state_r.addr;
  assign skip_fetched = state_r.skip;
  assign flag_z = state_r.z;
  assign flag_c = state_r.c;
  assign flag_dc = state_r.dc;
  assign avs_readdata = state_r.rdata;
  assign avs_waitrequest = state_r.wait_req;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_cmp_carry_flag: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    op_valid && op_ready && op_code == compare_op
    |=> flag_c == ($past(file_data) >= $past(acc_data)))
    else $error("compare carry does not match no-borrow");

  chk_cmp_no_store: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    op_valid && op_ready && op_code == compare_op
    |=> res_valid && !res_to_acc && !res_to_file && op_ready)
    else $error("compare stored a result or stalled");

  chk_dec_dest_val: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    op_valid && op_ready && op_code == count_down_op
    |=> res_data == $past(file_data) - ONE_VAL && res_to_file == $past(op_dest)
        && res_to_acc != $past(op_dest) && flag_c == $past(flag_c) && op_ready)
    else $error("count-down result, destination or carry wrong");

  chk_decsz_dest_val: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    op_valid && op_ready && op_code == count_down_skip_op
    |=> res_data == $past(file_data) - ONE_VAL && res_to_file == $past(op_dest)
        && res_to_acc != $past(op_dest))
    else $error("count-down-skip result or destination wrong");

  chk_skip_two_cycle: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    op_valid && op_ready && op_code == count_down_skip_op && file_data == ONE_VAL
    |=> skip_fetched && !op_ready ##1 !skip_fetched && op_ready)
    else $error("zero result did not give one nop cycle");

  chk_skip_none: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    op_valid && op_ready && op_code == count_down_skip_op && file_data != ONE_VAL
    |=> !skip_fetched && op_ready)
    else $error("non-zero result skipped");

  chk_bcd_flags_keep: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    op_valid && op_ready && op_code == bcd_adjust_op
    |=> res_to_acc && !res_to_file && flag_z == $past(flag_z) && flag_dc == $past(flag_dc))
    else $error("bcd adjust wrote wrong place or moved zero");

  chk_zero_flag_op: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    res_valid && $past(op_code) != bcd_adjust_op |-> flag_z == (res_data == ZERO_VAL))
    else $error("zero flag does not follow result");

  chk_bus_answer: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule : cdb_alu

// file: tb/cdb_core_model.sv
// partner model: working register, file registers and the add that precedes bcd adjust
`timescale 1ns/1ps
module cdb_core_model (
  input wire logic sys_clk,
  input wire logic [5:0] op_file_addr,
  input wire logic res_to_acc,
  input wire logic res_to_file,
  input wire logic [7:0] res_data,
  input wire logic [5:0] res_file_addr,
  output logic [7:0] file_data,
  output logic [7:0] acc_data,
  output logic ext_flag_we,
  output logic ext_z,
  output logic ext_c,
  output logic ext_dc
);
  logic [7:0] regs [64];
  logic [7:0] acc;

  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
    acc = 8'h00;
    ext_flag_we = 1'b0;
    ext_z = 1'b0;
    ext_c = 1'b0;
    ext_dc = 1'b0;
  end

  assign file_data = regs[op_file_addr];
  assign acc_data = acc;

  // write-back lands on the edge that closes the result cycle
  always @(posedge sys_clk) begin
    if (res_to_acc) begin
      acc <= res_data;
    end
    if (res_to_file) begin
      regs[res_file_addr] <= res_data;
    end
  end

  // ----------------------------------------------------------------
  // binary add; its flags reach the block as a one-cycle load
  // ----------------------------------------------------------------
  // caller must follow this directly with bcd adjust, nothing between
  task automatic add_file(input logic [5:0] a);
    logic [8:0] sum;
    sum = {1'b0, acc} + {1'b0, regs[a]};
    @(posedge sys_clk);
    acc <= sum[7:0];
    ext_flag_we <= 1'b1;
    ext_z <= (sum[7:0] == 8'h00);
    ext_c <= sum[8];
    ext_dc <= (({1'b0, acc[3:0]} + {1'b0, regs[a][3:0]}) > 5'h0F);
    @(posedge sys_clk);
    ext_flag_we <= 1'b0;
  endtask : add_file
endmodule : cdb_core_model

// file: tb/compare_decrement_bcd_alu_ops_tb.sv
// self-checking bench for the compare / count-down / bcd adjust datapath
`timescale 1ns/1ps
module compare_decrement_bcd_alu_ops_tb import cdb_pkg::*; ();
  logic sys_clk, arst_n, op_valid, op_dest;
  logic [1:0] op_code;
  logic [5:0] op_file_addr, res_file_addr;
  logic [7:0] file_data, acc_data, res_data;
  logic ext_flag_we, ext_z, ext_c, ext_dc;
  logic op_ready, res_valid, res_to_acc, res_to_file, skip_fetched, flag_z, flag_c, flag_dc;
  logic [3:0] avs_address, avs_byteenable;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  int errors, n_tests, n_ops;

  cdb_alu i_cdb_alu (.sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
    .op_dest(op_dest), .op_file_addr(op_file_addr), .file_data(file_data), .acc_data(acc_data),
    .ext_flag_we(ext_flag_we), .ext_z(ext_z), .ext_c(ext_c), .ext_dc(ext_dc), .op_ready(op_ready),
    .res_valid(res_valid), .res_data(res_data), .res_to_acc(res_to_acc), .res_to_file(res_to_file),
    .res_file_addr(res_file_addr), .skip_fetched(skip_fetched), .flag_z(flag_z), .flag_c(flag_c),
    .flag_dc(flag_dc), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  cdb_core_model i_cdb_core_model (.sys_clk(sys_clk), .op_file_addr(op_file_addr),
    .res_to_acc(res_to_acc), .res_to_file(res_to_file), .res_data(res_data),
    .res_file_addr(res_file_addr), .file_data(file_data), .acc_data(acc_data),
    .ext_flag_we(ext_flag_we), .ext_z(ext_z), .ext_c(ext_c), .ext_dc(ext_dc));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // let the model's write-back land before touching its registers
  task automatic settle;
    @(posedge sys_clk);
    #1;
  endtask : settle

  // offer one op while op_ready is high; returns inside the result cycle
  task automatic run_op(input logic [1:0] c, input logic d, input logic [5:0] a);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_dest <= d;
    op_file_addr <= a;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    n_ops++;
    #1;
    chk(res_valid, 1'b1);
  endtask : run_op

  task automatic chk_res(input logic [7:0] v, input logic to_acc, input logic to_file);
    chk(res_data, v);
    chk(res_to_acc, to_acc);
    chk(res_to_file, to_file);
  endtask : chk_res

  // avalon master: hold until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
    @(posedge sys_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    @(posedge sys_clk);
    // no cycle count assumed; only the watchdog ends a hung wait
    while (avs_waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_bus;
    chk(avs_waitrequest, 1'b1);
    bus(1'b0, FLAGS_OFS, 32'h0, 4'hF);
    chk(rdat, 32'h0);
    bus(1'b1, FLAGS_OFS, 32'h3, 4'h1);
    bus(1'b1, FLAGS_OFS, 32'h0, 4'h0);
    bus(1'b0, FLAGS_OFS, 32'h0, 4'hF);
    chk(rdat, 32'h3);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    chk(rdat, 32'h0);
    bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
    chk(rdat, 32'h8);
    $display("test bus finished");
  endtask : test_bus

  task automatic test_count_down;
    i_cdb_core_model.regs[5] = 8'h05;
    run_op(count_down_op, DEST_ACC, 6'h05);
    chk_res(8'h04, 1'b1, 1'b0);
    chk(flag_c, 1'b1);
    chk(flag_z, 1'b0);
    i_cdb_core_model.regs[63] = 8'h01;
    run_op(count_down_op, DEST_FILE, 6'h3F);
    chk_res(8'h00, 1'b0, 1'b1);
    chk(res_file_addr, 6'h3F);
    chk(flag_z, 1'b1);
    settle();
    chk(i_cdb_core_model.regs[63], 8'h00);
    chk(i_cdb_core_model.acc, 8'h04);
    $display("test count_down finished");
  endtask : test_count_down

  task automatic cmp_case(input logic [7:0] f, input logic [7:0] a, input logic z, input logic c);
    logic [7:0] d;
    d = f - a;
    settle();
    i_cdb_core_model.regs[10] = f;
    i_cdb_core_model.acc = a;
    run_op(compare_op, DEST_FILE, 6'h0A);
    chk_res(d, 1'b0, 1'b0);
    chk(flag_z, z);
    chk(flag_c, c);
    chk(op_ready, 1'b1);
    settle();
    chk(i_cdb_core_model.regs[10], f);
    chk(i_cdb_core_model.acc, a);
  endtask : cmp_case

  task automatic test_skip;
    i_cdb_core_model.regs[20] = 8'h02;
    i_cdb_core_model.regs[21] = 8'h01;
    i_cdb_core_model.regs[22] = 8'h80;
    run_op(count_down_skip_op, DEST_ACC, 6'h14);
    chk_res(8'h01, 1'b1, 1'b0);
    chk(skip_fetched, 1'b0);
    chk(op_ready, 1'b1);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= count_down_skip_op;
    op_dest <= DEST_FILE;
    op_file_addr <= 6'h15;
    @(posedge sys_clk);
    op_code <= count_down_op;
    op_dest <= DEST_ACC;
    op_file_addr <= 6'h16;
    #1;
    chk_res(8'h00, 1'b0, 1'b1);
    chk(skip_fetched, 1'b1);
    chk(op_ready, 1'b0);
    chk(flag_z, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(res_valid, 1'b0);
    @(posedge sys_clk);
    op_valid <= 1'b0;
    n_ops += 2;
    #1;
    chk(res_valid, 1'b1);
    chk_res(8'h7F, 1'b1, 1'b0);
    $display("test skip finished");
  endtask : test_skip

  task automatic bcd_case(input logic [7:0] a, input logic [7:0] r, input logic [7:0] v, input logic c,
                          input logic dc);
    settle();
    i_cdb_core_model.acc = a;
    i_cdb_core_model.regs[30] = r;
    i_cdb_core_model.add_file(6'h1E);
    run_op(bcd_adjust_op, DEST_ACC, 6'h00);
    chk_res(v, 1'b1, 1'b0);
    chk(flag_c, c);
    chk(flag_z, 1'b0);
    chk(flag_dc, dc);
  endtask : bcd_case

  // mid-run reset: outputs return to idle values, counter restarts
  task automatic test_reset;
    @(posedge sys_clk);
    arst_n <= 1'b0;
    #1;
    chk(flag_z, 1'b0);
    chk(flag_c, 1'b0);
    chk(flag_dc, 1'b0);
    chk(op_ready, 1'b1);
    chk(res_valid, 1'b0);
    chk(avs_waitrequest, 1'b1);
    chk(avs_readdata, 32'h0);
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    bus(1'b0, OPCNT_OFS, 32'h0, 4'hF);
    chk(rdat, 32'h0);
    $display("test reset finished");
  endtask : test_reset

  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    #(40 * 5000);
    errors++;
    report_and_stop();
  end

  initial begin
    {arst_n, op_valid, op_code, op_dest, op_file_addr} = '0;
    {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
    errors = 0;
    n_tests = 0;
    n_ops = 0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    test_bus();
    test_count_down();
    cmp_case(8'h34, 8'h12, 1'b0, 1'b1);
    cmp_case(8'h12, 8'h34, 1'b0, 1'b0);
    cmp_case(8'h55, 8'h55, 1'b1, 1'b1);
    $display("test compare finished");
    test_skip();
    bcd_case(8'h28, 8'h25, 8'h53, 1'b0, 1'b0);
    bcd_case(8'h09, 8'h09, 8'h18, 1'b0, 1'b1);
    bcd_case(8'h90, 8'h0A, 8'h00, 1'b1, 1'b0);
    $display("test bcd finished");
    bus(1'b0, OPCNT_OFS, 32'h0, 4'hF);
    chk(rdat, n_ops);
    test_reset();
    report_and_stop();
  end
endmodule : compare_decrement_bcd_alu_ops_tb
